//--- hw/port_led_indicator_mux.v
// Per-port status indicator multiplexer for a two-port switch.
// Assumes status inputs and straps are synchronous to ref_clk; indicators are
// active high and a high indicator output lights the lamp.
`timescale 1ns/1ps
`include "port_led_defines.vh"

module port_led_indicator_mux (
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       display_mode_sel_hi,
  input  wire       display_mode_sel_lo,
  input  wire       port1Link,
  input  wire       port1Activity,
  input  wire       port1Fast,
  input  wire       port1FullDuplex,
  input  wire       port1Collision,
  input  wire       port2Link,
  input  wire       port2Activity,
  input  wire       port2Fast,
  input  wire       port2FullDuplex,
  input  wire       port2Collision,
  input  wire [2:0] port1TestIn,
  input  wire [2:0] port2TestIn,
  output reg  [2:0] port1TestCapture,
  output reg  [2:0] port2TestCapture,
  output wire       port1_indicator_0,
  output wire       port1_indicator_1,
  output wire       port1_indicator_2,
  output wire       port1_indicator_3,
  output wire       port2_indicator_0,
  output wire       port2_indicator_1,
  output wire       port2_indicator_2,
  output wire       port2_indicator_3,
  output wire [2:0] port1IndicatorOeN,
  output wire [2:0] port2IndicatorOeN
);

  // Straps are used live each cycle; a strap change shows one cycle later
  wire [1:0] displayMode;
  wire [3:0] port1Ind_d;
  wire [3:0] port2Ind_d;
  reg  [3:0] port1Ind_q;
  reg  [3:0] port2Ind_q;

  assign displayMode = {display_mode_sel_hi, display_mode_sel_lo};

  // Lit only while linked and traffic is seen; the source shapes the blink
  function linkActivity;
    input link;
    input act;
    begin
      linkActivity = link & act;
    end
  endfunction

  // Indicator 0: speed, or full duplex in the split-speed mode
  function ind0Value;
    input [1:0] mode;
    input       fast;
    input       fdx;
    begin
      case (mode)
        `MODE_COMBINED:
        begin
          ind0Value = fast;
        end
        `MODE_SPLIT_SPEED:
        begin
          ind0Value = fdx;
        end
        default:
        begin
          ind0Value = fast;
        end
      endcase
    end
  endfunction

  // Indicator 1: duplex or collision, or slow link in the split-speed mode
  function ind1Value;
    input [1:0] mode;
    input       link;
    input       act;
    input       fast;
    input       fdx;
    input       col;
    begin
      case (mode)
        `MODE_COMBINED:
        begin
          ind1Value = fdx | col;
        end
        `MODE_SPLIT_SPEED:
        begin
          ind1Value = linkActivity(link, act) & ~fast;
        end
        default:
        begin
          ind1Value = fdx | col;
        end
      endcase
    end
  endfunction

  // Indicator 2: link with activity, fast link, or plain link
  function ind2Value;
    input [1:0] mode;
    input       link;
    input       act;
    input       fast;
    begin
      case (mode)
        `MODE_COMBINED:
        begin
          ind2Value = linkActivity(link, act);
        end
        `MODE_SPLIT_SPEED:
        begin
          ind2Value = linkActivity(link, act) & fast;
        end
        default:
        begin
          ind2Value = link;
        end
      endcase
    end
  endfunction

  // Indicator 3 has no job in the two lower modes and stays dark there
  function ind3Value;
    input [1:0] mode;
    input       act;
    begin
      case (mode)
        `MODE_COMBINED:
        begin
          ind3Value = 1'h0;
        end
        `MODE_SPLIT_SPEED:
        begin
          ind3Value = 1'h0;
        end
        default:
        begin
          ind3Value = act;
        end
      endcase
    end
  endfunction

  // One mapping shared by both ports so the two can never drift apart
  function [3:0] mapIndicators;
    input [1:0] mode;
    input       link;
    input       act;
    input       fast;
    input       fdx;
    input       col;
    begin
      mapIndicators[3] = ind3Value(mode, act);
      mapIndicators[2] = ind2Value(mode, link, act, fast);
      mapIndicators[1] = ind1Value(mode, link, act, fast, fdx, col);
      mapIndicators[0] = ind0Value(mode, fast, fdx);
    end
  endfunction

  // Activity pulses are short; lamps blink at whatever rate the status source gives
  assign port1Ind_d = mapIndicators(displayMode, port1Link, port1Activity,
                                    port1Fast, port1FullDuplex, port1Collision);
  assign port2Ind_d = mapIndicators(displayMode, port2Link, port2Activity,
                                    port2Fast, port2FullDuplex, port2Collision);

  // Indicators are forced dark for the whole of reset
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      port1Ind_q <= `IND_RESET;
    end
    else
    begin
      port1Ind_q <= port1Ind_d;
    end
  end

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      port2Ind_q <= `IND_RESET;
    end
    else
    begin
      port2Ind_q <= port2Ind_d;
    end
  end

  // Test lines sampled while reset holds; the last value before release is kept.
  // No reset here on purpose: the capture must run while reset is high.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      port1TestCapture <= port1TestIn;
    end
    else
    begin
      port1TestCapture <= port1TestCapture;
    end
  end

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      port2TestCapture <= port2TestIn;
    end
    else
    begin
      port2TestCapture <= port2TestCapture;
    end
  end

  // Active-low enables: lines 0..2 released to high impedance during reset
  assign port1IndicatorOeN = {`TEST_LINES{rst}};
  assign port2IndicatorOeN = {`TEST_LINES{rst}};

  assign port1_indicator_0 = port1Ind_q[0];
  assign port1_indicator_1 = port1Ind_q[1];
  assign port1_indicator_2 = port1Ind_q[2];
  assign port1_indicator_3 = port1Ind_q[3];
  assign port2_indicator_0 = port2Ind_q[0];
  assign port2_indicator_1 = port2Ind_q[1];
  assign port2_indicator_2 = port2Ind_q[2];
  assign port2_indicator_3 = port2Ind_q[3];

endmodule // port_led_indicator_mux

//--- hw/port_led_defines.vh
// Constants for the per-port status indicator multiplexer.
// Assumes inclusion by bare name from the indicator mux module.
// Behaviour
// - Port 1 has indicators 0..3, meaning picked by two-bit mode from two straps.
// - Port 2 uses the same four-mode mapping and the same shared mode straps.
// - Mode 00: ind2 link/activity, ind1 full duplex/collision, ind0 speed.
// - Mode 01: ind2 fast link/activity, ind1 slow link/activity, ind0 full duplex.
// - Modes 10/11: ind3 activity, ind2 link, ind1 duplex/collision, ind0 speed.
// - During hardware reset indicator lines 0..2 are test inputs, not driven.
`ifndef PORT_LED_DEFINES_VH
`define PORT_LED_DEFINES_VH

`define MODE_COMBINED     2'h0
`define MODE_SPLIT_SPEED  2'h1
`define MODE_SEPARATE_A   2'h2
`define MODE_SEPARATE_B   2'h3

`define IND_WIDTH         4
`define IND_RESET         4'h0
`define TEST_LINES        3

`endif

//--- dv/port_led_lamps.sv
// Board lamp model for both ports; released lines read the strap pattern on drv.
`timescale 1ns/1ps
module port_led_lamps (input wire [5:0] oeN, input wire [5:0] drv, input wire [5:0] ind,
  output wire [5:0] level);
  assign level = (~oeN & ind) | (oeN & drv);
endmodule // port_led_lamps

//--- dv/port_led_props.sv
// Checker on the pins of the indicator mux; bound to the mux.
`timescale 1ns/1ps
module port_led_props (input wire ref_clk, rst, display_mode_sel_hi, display_mode_sel_lo,
  port1Link, port1Activity, port1Fast, port1FullDuplex, port1Collision,
  port2Link, port2Activity, port2Fast, port2FullDuplex, port2Collision,
  port1_indicator_0, port1_indicator_1, port1_indicator_2, port1_indicator_3,
  port2_indicator_0, port2_indicator_1, port2_indicator_2, port2_indicator_3,
  input wire [2:0] port1IndicatorOeN);
  wire [3:0] j = {port2_indicator_3, port2_indicator_2, port2_indicator_1, port2_indicator_0};
  wire [3:0] e2 = {port2Activity, port2Link, port2FullDuplex | port2Collision, port2Fast};
  wire [1:0] m = {display_mode_sel_hi, display_mode_sel_lo};
  wire la = port1Link & port1Activity;
  wire [3:0] i = {port1_indicator_3, port1_indicator_2, port1_indicator_1, port1_indicator_0};
  wire [3:0] e = {port1Activity, port1Link, port1FullDuplex | port1Collision, port1Fast};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_sep; display_mode_sel_hi |=> i == $past(e); endproperty
  a_sep: assert property (p_sep) else $error("separate map wrong");
  property p_spare; !display_mode_sel_hi |=> !port1_indicator_3; endproperty
  a_spare: assert property (p_spare) else $error("spare lamp lit");
  property p_oe; disable iff (1'b0) port1IndicatorOeN == {3{rst}}; endproperty
  a_oe: assert property (p_oe) else $error("enable wrong");
  property p_comb; m == 2'h0 |=> i == $past({1'h0, la, e[1], port1Fast}); endproperty
  a_comb: assert property (p_comb) else $error("combined map wrong");
  property p_split;
    m == 2'h1 |=> i == $past({1'h0, la & port1Fast, la & !port1Fast, port1FullDuplex});
  endproperty
  a_split: assert property (p_split) else $error("split map wrong");
  property p_port2; display_mode_sel_hi |=> j == $past(e2); endproperty
  a_port2: assert property (p_port2) else $error("port 2 map wrong");
  property p_dark; disable iff (1'b0) rst |=> i == 4'h0 && j == 4'h0; endproperty
  a_dark: assert property (p_dark) else $error("lamp lit in reset");
endmodule // port_led_props
bind port_led_indicator_mux port_led_props props_u (.*);

//--- dv/port_led_indicator_mux_tb_top.sv
// Testbench: test capture under reset, then every mode and status pattern.
`timescale 1ns/1ps
module port_led_indicator_mux_tb_top;
  logic ref_clk = 0, rst = 1, display_mode_sel_hi = 0, display_mode_sel_lo = 0;
  logic port1Link = 0, port1Activity = 0, port1Fast = 0, port1FullDuplex = 0, port1Collision = 0;
  logic port2Link = 0, port2Activity = 0, port2Fast = 0, port2FullDuplex = 0, port2Collision = 0;
  logic [2:0] pat = 3'h5;
  int err_total = 0, total_checks = 0;
  wire [2:0] port1TestIn, port2TestIn, port1TestCapture, port2TestCapture;
  wire [2:0] port1IndicatorOeN, port2IndicatorOeN;
  wire port1_indicator_0, port1_indicator_1, port1_indicator_2, port1_indicator_3;
  wire port2_indicator_0, port2_indicator_1, port2_indicator_2, port2_indicator_3;
  wire [3:0] i1 = {port1_indicator_3, port1_indicator_2, port1_indicator_1, port1_indicator_0};
  wire [3:0] i2 = {port2_indicator_3, port2_indicator_2, port2_indicator_1, port2_indicator_0};
  port_led_indicator_mux dut_u (.*);
  port_led_lamps lamp_u (.oeN({port2IndicatorOeN, port1IndicatorOeN}), .drv({~pat, pat}),
    .ind({i2[2:0], i1[2:0]}), .level({port2TestIn, port1TestIn}));
  always #50 ref_clk = ~ref_clk;
  // s holds link, activity, fast, full duplex, collision from bit 4 down
  function automatic [3:0] f(input [1:0] m, input [4:0] s);
    f = m[1] ? {s[3], s[4], s[1] | s[0], s[2]} : m[0] ?
      {1'b0, &s[4:2], s[4] & s[3] & !s[2], s[1]} : {1'b0, s[4] & s[3], s[1] | s[0], s[2]};
  endfunction
  task chk(input [5:0] got, input [5:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task reset_test;
    repeat (10) @(negedge ref_clk);
    chk({port2IndicatorOeN, port1IndicatorOeN}, 6'h3f);
    chk({port2TestCapture, port1TestCapture}, {~pat, pat});
    chk({i2, i1[1:0]}, 6'h00);
    rst = 0;
    pat = 3'h2;
    @(negedge ref_clk);
    chk({port2IndicatorOeN, port1IndicatorOeN}, 6'h00);
    chk({port2TestCapture, port1TestCapture}, 6'h15);
  endtask
  task mode_sweep;
    for (int k = 0; k < 128; k++)
    begin
      {display_mode_sel_hi, display_mode_sel_lo} = k[6:5];
      {port1Link, port1Activity, port1Fast, port1FullDuplex, port1Collision} = k[4:0];
      {port2Link, port2Activity, port2Fast, port2FullDuplex, port2Collision} = ~k[4:0];
      @(negedge ref_clk);
      chk({2'h0, i1}, {2'h0, f(k[6:5], k[4:0])});
      chk({2'h0, i2}, {2'h0, f(k[6:5], ~k[4:0])});
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    reset_test;
    mode_sweep;
    report_and_stop;
  end
endmodule // port_led_indicator_mux_tb_top
